// *** sfir_defines.svh ***
// Constants for the symmetric FIR filter: sizes, option defaults, stage latencies.
// Assumes it is included by the package, the filter and the test bench files only.
`ifndef SFIR_DEFINES_SVH
`define SFIR_DEFINES_SVH

// Geometry
`define SFIR_TAPS 44
`define SFIR_SAMPLE_W 16
`define SFIR_COEF_W 10
`define SFIR_FRAC_W 9
`define SFIR_ACC_W 33
`define SFIR_COEF_DEFAULT 10'h040

// Option defaults
`define SFIR_USE_EVEN 1'b1
`define SFIR_USE_ROUNDING 1'b1
`define SFIR_USE_SATURATE 1'b1
`define SFIR_ANTISYM 1'b1

// Latency terms in enabled clock cycles
`define SFIR_RND_LAT 2
`define SFIR_SAT_LAT 1
`define SFIR_EVEN_BASE 4
`define SFIR_ODD_BASE 6
`define SFIR_CORE_LAT 4

// Output buffer
`define SFIR_FIFO_DEPTH 4

`endif

// *** sfir_fifo.sv ***
// Small flip-flop FIFO with valid and ready on both sides.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/100ps
`default_nettype none

module sfir_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 4
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic wr_valid,
  output logic wr_ready,
  input wire logic [WIDTH-1:0] wr_data,
  output logic rd_valid,
  input wire logic rd_ready,
  output logic [WIDTH-1:0] rd_data
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CNT_W = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [PW-1:0] wr_ptr_reg;
  logic [PW-1:0] rd_ptr_reg;
  logic [CNT_W-1:0] count_reg;
  logic [CNT_W-1:0] count_next;
  logic push;
  logic pop;

  // Handshakes and occupancy
  assign push = wr_valid & wr_ready;
  assign pop = rd_valid & rd_ready;
  assign count_next = count_reg + CNT_W'(push) - CNT_W'(pop);
  assign rd_data = mem_reg[rd_ptr_reg];

  // Storage, written only on an accepted push
  always_ff @(posedge clock) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= wr_data;
    end
  end

  // Pointers and registered flags
  always_ff @(posedge clock) begin
    if (reset) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
      wr_ready <= 1'b0;
      rd_valid <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == PW'(DEPTH - 1)) ? '0 : wr_ptr_reg + PW'(1);
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == PW'(DEPTH - 1)) ? '0 : rd_ptr_reg + PW'(1);
      end
      count_reg <= count_next;
      wr_ready <= (count_next != CNT_W'(DEPTH)); // Not full
      rd_valid <= (count_next != '0); // Not empty
    end
  end
endmodule : sfir_fifo

`default_nettype wire

// *** sfir_filter.sv ***
// Pipelined symmetric FIR filter with rounding, saturation and output FIFO.
// Assumes samples synchronous to clock; en qualifies every edge.
`timescale 1ns/100ps
`default_nettype none
`include "sfir_defines.svh"

module sfir_filter #(
  parameter int TAPS = `SFIR_TAPS,
  parameter bit USE_EVEN = `SFIR_USE_EVEN,
  parameter bit USE_ROUNDING = `SFIR_USE_ROUNDING,
  parameter bit USE_SATURATE = `SFIR_USE_SATURATE,
  parameter bit antisymmetric_select = `SFIR_ANTISYM,
  parameter logic [((TAPS+1)/2)*`SFIR_COEF_W-1:0] COEFS = {((TAPS+1)/2){`SFIR_COEF_DEFAULT}}
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic en,
  input wire logic signed [`SFIR_SAMPLE_W-1:0] x_in,
  output logic x_ready,
  output logic signed [`SFIR_SAMPLE_W-1:0] y_out,
  output logic out_valid,
  input wire logic out_ready,
  output logic [`SFIR_SAMPLE_W-1:0] out_data
);
  // ---------------------------------------------------------------
  // Sizes and latency
  // ---------------------------------------------------------------
  localparam int sample_width = `SFIR_SAMPLE_W;
  localparam int coefficient_bits = `SFIR_COEF_W;
  localparam int fraction_bits = `SFIR_FRAC_W;
  localparam int HALF = TAPS / 2;
  localparam int NPROD = (TAPS + 1) / 2;
  localparam int PW = sample_width + 1;
  localparam int MW = PW + coefficient_bits;
  localparam int AW = `SFIR_ACC_W;
  localparam int RL = USE_ROUNDING ? `SFIR_RND_LAT : 0;
  localparam int SL = USE_SATURATE ? `SFIR_SAT_LAT : 0;
  localparam int LAT = USE_EVEN ? (TAPS / 2 + RL + SL + `SFIR_EVEN_BASE)
                                : ((TAPS - 1) / 2 + RL + SL + `SFIR_ODD_BASE);
  localparam int PAD = LAT - `SFIR_CORE_LAT - RL - SL;
  localparam int FILL_W = $clog2(LAT + 1);
  localparam logic signed [AW-1:0] RB_POS = AW'(1) <<< (fraction_bits - 1);
  localparam logic signed [AW-1:0] RB_NEG = RB_POS - AW'(1);
  localparam logic signed [AW-1:0] MAX_W = AW'({1'b0, {(sample_width-1){1'b1}}});
  localparam logic signed [AW-1:0] MIN_W = -MAX_W - AW'(1);

  // Sign-extends one sample to the pre-adder width
  function automatic logic signed [PW-1:0] sx(input logic signed [sample_width-1:0] v);
    sx = {v[sample_width-1], v};
  endfunction : sx

  logic step;
  logic fifo_ready;
  logic push;
  logic [FILL_W-1:0] fill_reg;
  sfir_pkg::sfir_sample_t tap_reg [TAPS];
  logic signed [PW-1:0] pre_reg [NPROD];
  logic signed [MW-1:0] prod_reg [NPROD];
  sfir_pkg::sfir_acc_t acc_next;
  sfir_pkg::sfir_acc_t sum_reg;
  sfir_pkg::sfir_acc_t rnd_out;
  sfir_pkg::sfir_sample_t nar;
  sfir_pkg::sfir_sample_t pad_reg [PAD];
  sfir_pkg::sfir_sample_t push_data;

  // Pipeline advances only on enabled edges with room downstream
  assign step = en & fifo_ready;

  // ---------------------------------------------------------------
  // Input delay line
  // ---------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (reset) begin
      for (int i = 0; i < TAPS; i++) tap_reg[i] <= '0;
    end else if (step) begin
      tap_reg[0] <= x_in;
      for (int i = 1; i < TAPS; i++) tap_reg[i] <= tap_reg[i-1];
    end
  end

  a_input_capture: assert property (@(posedge clock) disable iff (reset)
    step |=> tap_reg[0] == $past(x_in)) else $error("input not captured");

  // ---------------------------------------------------------------
  // Pair pre-add and coefficient multiply
  // ---------------------------------------------------------------
  for (genvar g = 0; g < NPROD; g++) begin : g_prod
    // Mirrored pair or centre tap
    always_ff @(posedge clock) begin
      if (reset) begin
        pre_reg[g] <= '0;
      end else if (step) begin
        if (g < HALF) begin
          pre_reg[g] <= antisymmetric_select ? (sx(tap_reg[g]) - sx(tap_reg[TAPS-1-g]))
                                             : (sx(tap_reg[g]) + sx(tap_reg[TAPS-1-g]));
        end else begin
          pre_reg[g] <= sx(tap_reg[HALF]);
        end
      end
    end

    // Signed fixed-point coefficient product
    always_ff @(posedge clock) begin
      if (reset) begin
        prod_reg[g] <= '0;
      end else if (step) begin
        prod_reg[g] <= pre_reg[g] * $signed(COEFS[g*coefficient_bits +: coefficient_bits]);
      end
    end
  end

  a_pair_preadd: assert property (@(posedge clock) disable iff (reset)
    step |=> pre_reg[0] == (antisymmetric_select ?
      $past(sx(tap_reg[0])) - $past(sx(tap_reg[TAPS-1]))
      : $past(sx(tap_reg[0])) + $past(sx(tap_reg[TAPS-1]))))
    else $error("pair pre-add wrong");

  a_coef_product: assert property (@(posedge clock) disable iff (reset)
    step |=> prod_reg[0] == MW'($past(pre_reg[0])
      * $signed(COEFS[coefficient_bits-1:0]))) else $error("product wrong");

  // ---------------------------------------------------------------
  // Accumulate products
  // ---------------------------------------------------------------
  always_comb begin
    acc_next = '0;
    for (int k = 0; k < NPROD; k++) acc_next = acc_next + AW'(prod_reg[k]);
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      sum_reg <= '0;
    end else if (step) begin
      sum_reg <= acc_next;
    end
  end

  // ---------------------------------------------------------------
  // Rounding: bias then drop fraction, or plain truncation
  // ---------------------------------------------------------------
  if (USE_ROUNDING) begin : g_rnd
    sfir_pkg::sfir_acc_t bias_reg;
    sfir_pkg::sfir_acc_t rnd_reg;

    // Two registered stages
    always_ff @(posedge clock) begin
      if (reset) begin
        bias_reg <= '0;
        rnd_reg <= '0;
      end else if (step) begin
        bias_reg <= sum_reg + (sum_reg[AW-1] ? RB_NEG : RB_POS);
        rnd_reg <= bias_reg >>> fraction_bits;
      end
    end
    assign rnd_out = rnd_reg;

    a_round_bias: assert property (@(posedge clock) disable iff (reset)
      step && !sum_reg[AW-1] |=> bias_reg == $past(sum_reg) + RB_POS)
      else $error("positive bias wrong");

    a_round_delay: assert property (@(posedge clock) disable iff (reset)
      step ##1 step |=> rnd_reg == ($past(sum_reg, 2) + ($past(sum_reg[AW-1], 2)
        ? RB_NEG : RB_POS)) >>> fraction_bits) else $error("rounding delay wrong");
  end else begin : g_trunc
    assign rnd_out = sum_reg >>> fraction_bits;
  end

  // ---------------------------------------------------------------
  // Saturation to the output width, or wrap
  // ---------------------------------------------------------------
  if (USE_SATURATE) begin : g_sat
    sfir_pkg::sfir_sample_t sat_reg;

    // One registered clamp stage
    always_ff @(posedge clock) begin
      if (reset) begin
        sat_reg <= '0;
      end else if (step) begin
        if (rnd_out > MAX_W) begin
          sat_reg <= MAX_W[sample_width-1:0];
        end else if (rnd_out < MIN_W) begin
          sat_reg <= MIN_W[sample_width-1:0];
        end else begin
          sat_reg <= rnd_out[sample_width-1:0];
        end
      end
    end
    assign nar = sat_reg;

    a_sat_clamp: assert property (@(posedge clock) disable iff (reset)
      step && (rnd_out > MAX_W) |=> sat_reg == MAX_W[sample_width-1:0])
      else $error("positive clamp missing");

    a_sat_delay: assert property (@(posedge clock) disable iff (reset)
      step && (rnd_out <= MAX_W) && (rnd_out >= MIN_W)
      |=> sat_reg == $past(rnd_out[sample_width-1:0])) else $error("sat delay wrong");
  end else begin : g_wrap
    assign nar = rnd_out[sample_width-1:0];
  end

  // ---------------------------------------------------------------
  // Output delay line, sized to meet the total latency
  // ---------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (reset) begin
      for (int i = 0; i < PAD; i++) pad_reg[i] <= '0;
    end else if (step) begin
      pad_reg[0] <= nar;
      for (int i = 1; i < PAD; i++) pad_reg[i] <= pad_reg[i-1];
    end
  end
  assign y_out = pad_reg[PAD-1];

  if (PAD > 1) begin : g_pd_chain
    assign push_data = pad_reg[PAD-2];
  end else begin : g_pd_direct
    assign push_data = nar;
  end

  a_hold_disabled: assert property (@(posedge clock) disable iff (reset)
    !step |=> $stable(y_out) && $stable(sum_reg) && $stable(tap_reg[0]))
    else $error("pipeline moved while disabled");

  // ---------------------------------------------------------------
  // Fill count: first valid output after LAT enabled cycles
  // ---------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (reset) begin
      fill_reg <= '0;
    end else if (step && (fill_reg != FILL_W'(LAT - 1))) begin
      fill_reg <= fill_reg + FILL_W'(1);
    end
  end
  assign push = step && (fill_reg == FILL_W'(LAT - 1));

  a_first_output: assert property (@(posedge clock) disable iff (reset)
    $rose(fill_reg == FILL_W'(LAT - 1)) |-> $past(step) && !out_valid)
    else $error("first output at wrong cycle");

  // ---------------------------------------------------------------
  // Output buffer; its back-pressure stalls the whole pipeline
  // ---------------------------------------------------------------
  sfir_fifo #(
    .WIDTH(sample_width),
    .DEPTH(`SFIR_FIFO_DEPTH)
  ) sfir_fifo_inst (
    .clock(clock),
    .reset(reset),
    .wr_valid(push),
    .wr_ready(fifo_ready),
    .wr_data(push_data),
    .rd_valid(out_valid),
    .rd_ready(out_ready),
    .rd_data(out_data)
  );
  assign x_ready = fifo_ready;
endmodule : sfir_filter

`default_nettype wire

// *** sfir_pkg.sv ***
// Types shared by the symmetric FIR filter files.
// Assumes sfir_defines.svh is on the include path.
`include "sfir_defines.svh"

package sfir_pkg;
  typedef logic signed [`SFIR_SAMPLE_W-1:0] sfir_sample_t;
  typedef logic signed [`SFIR_COEF_W-1:0] sfir_coef_t;
  typedef logic signed [`SFIR_ACC_W-1:0] sfir_acc_t;
endpackage : sfir_pkg

// *** sfir_sink.sv ***
// Downstream consumer model for the filter output FIFO.
// Assumes the filter clock; the bench picks the ready pattern.
`timescale 1ns/100ps
`default_nettype none

module sfir_sink (
  input wire logic clock,
  input wire logic [1:0] mode,
  output logic out_ready
);
  int seed = 23491;

  // Ready just after each edge: 0 always, 1 random stalls, 2 blocked
  initial out_ready = 1'b0;
  always @(posedge clock) begin
    #1;
    case (mode)
      2'h0: out_ready = 1'b1;
      2'h1: out_ready = ($random(seed) & 3) != 0;
      default: out_ready = 1'b0;
    endcase
  end
endmodule : sfir_sink

`default_nettype wire

// *** symmetric_fir_latency_pipeline_test.sv ***
// Self-checking bench: even filter with FIFO, odd filter without rounding and saturation stages.
// Assumes sfir_defines.svh on the include path; 100 MHz clock.
`timescale 1ns/100ps
`default_nettype none
`include "sfir_defines.svh"

module symmetric_fir_latency_pipeline_test;
  localparam int TAPS = `SFIR_TAPS;
  localparam int LAT = TAPS / 2 + 2 + 1 + 4;
  localparam int LAT2 = (43 - 1) / 2 + 6;
  localparam int COEF = `SFIR_COEF_DEFAULT;
  logic clock;
  logic reset;
  logic en;
  logic en2;
  logic x_ready;
  logic out_valid;
  logic out_ready;
  logic st;
  logic pop;
  logic [1:0] mode;
  logic [15:0] out_data;
  logic [15:0] pd;
  sfir_pkg::sfir_sample_t x_in;
  sfir_pkg::sfir_sample_t y_out;
  sfir_pkg::sfir_sample_t y_out2;
  sfir_pkg::sfir_sample_t yp;
  sfir_pkg::sfir_sample_t y2p;
  sfir_pkg::sfir_sample_t hist [0:1023];
  sfir_pkg::sfir_sample_t exp_a [0:1023];
  sfir_pkg::sfir_sample_t exp_b [0:1023];
  sfir_pkg::sfir_sample_t exp_q [$];
  int error_cnt = 0;
  int checked = 0;
  int ns = 0;
  int sc = 0;
  int cycles = 0;
  int seed = 23491;

  // Odd filter steps exactly when the even one does
  assign en2 = en & x_ready;

  sfir_filter sfir_filter_inst (.clock(clock), .reset(reset), .en(en), .x_in(x_in),
    .x_ready(x_ready), .y_out(y_out), .out_valid(out_valid), .out_ready(out_ready),
    .out_data(out_data));
  // Odd filter uses plain symmetric pairs so the adding pre-add is exercised too
  sfir_filter #(.TAPS(43), .USE_EVEN(1'b0), .USE_ROUNDING(1'b0), .USE_SATURATE(1'b0),
    .antisymmetric_select(1'b0),
    .COEFS({10'h000, {21{10'h040}}})) sfir_filter_odd_inst (.clock(clock), .reset(reset),
    .en(en2), .x_in(x_in), .x_ready(), .y_out(y_out2), .out_valid(), .out_ready(1'b1),
    .out_data());
  sfir_sink sfir_sink_inst (.clock(clock), .mode(mode), .out_ready(out_ready));

  function automatic int hv(input int i);
    return (i < 0) ? 0 : int'(hist[i]);
  endfunction : hv

  // Reference output for sample s; lim selects rounding and saturation
  function automatic sfir_pkg::sfir_sample_t model(input int s, input int taps, input bit lim,
                                                   input bit anti);
    longint acc;
    acc = 0;
    for (int g = 0; g < taps / 2; g++) begin
      acc += COEF * (hv(s - g) + (anti ? -hv(s - taps + 1 + g) : hv(s - taps + 1 + g)));
    end
    if (lim) begin
      acc = (acc >= 0) ? acc + 256 : acc + 255;
    end
    acc = acc >>> `SFIR_FRAC_W;
    if (lim) begin
      acc = (acc > 32767) ? 32767 : (acc < -32768) ? -32768 : acc;
    end
    return acc[15:0];
  endfunction : model

  task automatic chk(input logic [15:0] got, input logic [15:0] want, input string what);
    checked++;
    if (got !== want) begin
      error_cnt++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, want);
    end
  endtask : chk

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : give_verdict

  task automatic do_reset();
    reset = 1'b1;
    en = 1'b0;
    repeat (3) @(posedge clock);
    #1;
    chk({14'h0000, x_ready, out_valid}, 16'h0000, "flags in reset");
    chk(y_out, 16'h0000, "y_out in reset");
    exp_q.delete();
    ns = 0;
    sc = 0;
    reset = 1'b0;
  endtask : do_reset

  // One sample after idle cycles with en low; held until taken, then noted
  task automatic send(input sfir_pkg::sfir_sample_t v, input int idle);
    repeat (idle) begin
      en = 1'b0;
      x_in = ~v;
      @(posedge clock);
      #1;
    end
    en = 1'b1;
    x_in = v;
    @(posedge clock);
    while (x_ready !== 1'b1) begin
      @(posedge clock);
    end
    hist[ns] = v;
    exp_a[ns] = model(ns, TAPS, 1'b1, 1'b1);
    exp_b[ns] = model(ns, 43, 1'b0, 1'b0);
    exp_q.push_back(exp_a[ns]);
    ns++;
    #1;
  endtask : send

  // Watches every edge: y_out timing and hold, FIFO pops against the notes
  always @(posedge clock) begin
    st = en === 1'b1 && x_ready === 1'b1 && reset === 1'b0;
    pop = out_valid === 1'b1 && out_ready === 1'b1 && reset === 1'b0;
    pd = out_data;
    yp = y_out;
    y2p = y_out2;
    sc += st;
    #2;
    if (st) begin
      chk(y_out, (sc >= LAT) ? exp_a[sc - LAT] : 16'h0000, "y_out");
      chk(y_out2, (sc >= LAT2) ? exp_b[sc - LAT2] : 16'h0000, "odd y");
    end else if (reset === 1'b0) begin
      chk(y_out, yp, "y_out hold");
      chk(y_out2, y2p, "odd hold");
    end
    if (pop) begin
      chk(pd, (exp_q.size() > 0) ? exp_q.pop_front() : ~pd, "out_data");
    end
  end

  // Cycle ceiling against a hang
  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      error_cnt++;
      $display("unexpected at %0t: timed out", $time);
      give_verdict();
    end
  end

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  initial begin
    x_in = 16'sh0000;
    mode = 2'h0;
    do_reset();
    // Impulse: +0.625 rounds up to 1 and -0.625 down to -1, mirrored pairs subtracted
    send(16'sh0005, 0);
    repeat (60) send(16'sh0000, 0);
    $display("test impulse done");
    // Full-scale steps, random gaps and stalls: clamp or wrap
    do_reset();
    mode = 2'h1;
    for (int i = 0; i < 80; i++) begin
      send((i < 40) ? 16'sh7FFF : 16'sh8000, (($random(seed) & 3) == 0) ? 2 : 0);
    end
    $display("test steps done");
    // Random samples; consumer blocked for 30 cycles, FIFO checked full and refusing, then drained
    do_reset();
    mode = 2'h0;
    for (int i = 0; i < 120; i++) begin
      if (i == 40) begin
        mode = 2'h2;
        fork
          begin
            repeat (30) @(posedge clock);
            #1;
            chk({15'h0000, x_ready}, 16'h0000, "full x_ready");
            chk({15'h0000, out_valid}, 16'h0001, "full out_valid");
            mode = 2'h0;
          end
        join_none
      end
      send(16'($random(seed)), 0);
    end
    en = 1'b0;
    repeat (10) @(posedge clock);
    #1;
    chk({15'h0000, out_valid}, 16'h0000, "drained");
    $display("test fifo done");
    give_verdict();
  end
endmodule : symmetric_fir_latency_pipeline_test

`default_nettype wire
